// ### verilog/rohp_channel.sv
`timescale 1ns/1ns
`include "rohp_regs.svh"

module rohp_channel #(
    parameter int          NPART    = 18,     // buffer partitions
    parameter int          FIFO_AW  = 9,      // output fifo address bits
    parameter logic        CHAN_SEL = 1'b0,   // value of host A[20] selecting this channel
    parameter logic [17:0] ENA_RST  = 18'h0   // partition enables after reset
) (
    input  wire logic        i_mclk,              // 125 MHz clock
    input  wire logic        i_nrst,              // power-on / system reset, active low
    input  wire logic        i_logic_rst_n,       // host flag: channel logic reset, active low
    // register port
    input  wire logic [5:0]  i_reg_addr,          // register index
    input  wire logic        i_reg_wr,            // write strobe
    input  wire logic        i_reg_rd,            // read strobe
    input  wire logic [31:0] i_reg_wdata,         // write data
    output logic      [31:0] o_reg_rdata,         // read data, registered
    // host external bus
    input  wire logic [20:0] i_host_addr,         // host address
    input  wire logic        i_fifo_read_space,   // read cycle in fifo space
    input  wire logic        i_buffer_test_space, // cycle in buffer access space
    input  wire logic        i_host_wr,           // host write cycle
    input  wire logic [31:0] i_host_wdata,        // host write data
    output logic      [31:0] o_fifo_rdata,        // output fifo word, registered
    output logic      [31:0] o_buf_host_rdata,    // buffer word for host, registered
    output logic             o_dma_req,           // dma request to host
    // output fifo fill side
    input  wire logic [31:0] i_ofifo_wdata,       // word from output controller
    input  wire logic        i_ofifo_wvalid,      // word valid
    output logic             o_ofifo_wready,      // fifo can take a word
    // buffer memory second port
    input  wire logic [19:0] i_int_buf_addr,      // read-out address generator
    input  wire logic [31:0] i_buf_rdata,         // buffer read data
    output logic      [19:0] o_buf_addr,          // buffer address, registered
    output logic             o_buf_we,            // buffer write, registered
    output logic      [31:0] o_buf_wdata,         // buffer write data, registered
    output logic             o_buf_host_mode,     // second port owned by host
    // read-out controller
    input  wire logic        i_ptr_valid,         // pointer pair valid
    input  wire logic [4:0]  i_ptr_part,          // partition of pointer pair
    input  wire logic [12:0] i_wr_ptr,            // partition write pointer
    input  wire logic [12:0] i_rd_ptr,            // partition read pointer
    input  wire logic        i_ro_event_start,    // start of event read-out
    input  wire logic        i_ro_word,           // one word read out
    input  wire logic [4:0]  i_ro_part,           // partition being read out
    output logic [NPART-1:0] o_part_enable,       // read-out enables
    // separator recognition
    input  wire logic        i_sep_valid,         // separator recognised
    input  wire logic [31:0] i_sep_word,          // recognised separator word
    // input link
    input  wire logic        i_link_down_n,       // link down, active low, async
    output logic             o_link_reset,        // one-cycle link reset and fifo clear
    output logic             o_freeze,            // pipeline frozen
    // interrupt sources and enables
    input  wire logic [2:0]  i_irq_en,            // enables: readout, link, event id
    input  wire logic        i_msg_fifo_full,     // message fifo full
    input  wire logic        i_fe_parity_err,     // front-end parity error
    input  wire logic        i_link_parity_err,   // link parity check failure
    input  wire logic        i_event_id_out,      // trailer outside window
    input  wire logic        i_elf_empty,         // event length fifo empty
    output logic             o_elf_empty_flag,    // host flag input, registered
    // open-drain interrupt pins, active low
    input  wire logic        i_readout_error_irq,   // pin level
    output logic             o_readout_error_irq,   // pin drive value
    output logic             o_readout_error_irq_oe, // pin driven
    input  wire logic        i_link_error_irq,      // pin level
    output logic             o_link_error_irq,      // pin drive value
    output logic             o_link_error_irq_oe,   // pin driven
    input  wire logic        i_event_id_window_irq, // pin level
    output logic             o_event_id_window_irq, // pin drive value
    output logic             o_event_id_window_irq_oe // pin driven
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (NPART < 1 || NPART > 18)
    begin : g_chk_npart
        $error("NPART must be 1 to 18");
    end
    if (FIFO_AW < 2 || FIFO_AW > 16)
    begin : g_chk_aw
        $error("FIFO_AW must be 2 to 16");
    end

    // ****************************************************************
    // reset and pin synchronisers
    // ****************************************************************
    logic lrst_s1_q;
    logic lrst_s2_q;
    logic ldn_s1_q;
    logic ldn_s2_q;
    logic soft_rst;

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            lrst_s1_q <= 1'b1;
            lrst_s2_q <= 1'b1;
        end
        else
        begin
            lrst_s1_q <= i_logic_rst_n;
            lrst_s2_q <= lrst_s1_q;
        end
    end

    // link side is reset only by system reset
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ldn_s1_q <= 1'b1;
            ldn_s2_q <= 1'b1;
        end
        else
        begin
            ldn_s1_q <= i_link_down_n;
            ldn_s2_q <= ldn_s1_q;
        end
    end

    assign soft_rst = !lrst_s2_q;

    // ****************************************************************
    // register decode
    // ****************************************************************
    rohp_pkg::rohp_regsel_e sel;

    always_comb
    begin
        if (i_reg_addr == `ROHP_OFS_CTRL)
            sel = rohp_pkg::SEL_CTRL;
        else if (i_reg_addr == `ROHP_OFS_MAXEV)
            sel = rohp_pkg::SEL_MAXEV;
        else if (i_reg_addr == `ROHP_OFS_PART_ENA)
            sel = rohp_pkg::SEL_PART_ENA;
        else if (i_reg_addr == `ROHP_OFS_SEP_FLAGS)
            sel = rohp_pkg::SEL_SEP_FLAGS;
        else
            sel = rohp_pkg::SEL_NONE;
    end

    // ****************************************************************
    // control register
    // ****************************************************************
    logic ctrl_bufmode_q;
    logic ctrl_linkrst_q;
    logic ctrl_freeze_q;
    logic linkrst_prev_q;
    logic link_reset_q;

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ctrl_bufmode_q <= 1'b0;
            ctrl_linkrst_q <= 1'b0;
            ctrl_freeze_q  <= `ROHP_FREEZE_RST;
        end
        else if (soft_rst)
        begin
            ctrl_bufmode_q <= 1'b0;
            ctrl_linkrst_q <= 1'b0;
            ctrl_freeze_q  <= `ROHP_FREEZE_RST;
        end
        else if (i_reg_wr && sel == rohp_pkg::SEL_CTRL)
        begin
            ctrl_bufmode_q <= i_reg_wdata[`ROHP_CTRL_BUFMODE];
            ctrl_linkrst_q <= i_reg_wdata[`ROHP_CTRL_LINKRST];
            ctrl_freeze_q  <= i_reg_wdata[`ROHP_CTRL_FREEZE];
        end
    end

    // edge detector shares the logic reset, so a reset never fires a link reset
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            linkrst_prev_q <= 1'b0;
            link_reset_q   <= 1'b0;
        end
        else if (soft_rst)
        begin
            linkrst_prev_q <= 1'b0;
            link_reset_q   <= 1'b0;
        end
        else
        begin
            linkrst_prev_q <= ctrl_linkrst_q;
            link_reset_q   <= ctrl_linkrst_q && !linkrst_prev_q;
        end
    end

    assign o_link_reset = link_reset_q;
    assign o_freeze     = ctrl_freeze_q;

    // ****************************************************************
    // maximum event size and oversize detection
    // ****************************************************************
    logic [11:0] maxev_q;
    logic [12:0] ev_cnt_q;
    logic [12:0] ev_cnt_base;
    logic        ev_over_q;
    logic        over_hit;

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            maxev_q <= `ROHP_MAXEV_RST;
        else if (soft_rst)
            maxev_q <= `ROHP_MAXEV_RST;
        else if (i_reg_wr && sel == rohp_pkg::SEL_MAXEV)
            maxev_q <= i_reg_wdata[11:0];
    end

    assign ev_cnt_base = i_ro_event_start ? 13'h0 : ev_cnt_q;
    // counter stops at the first excess word, so it cannot wrap
    assign over_hit    = i_ro_word && !ev_over_q
                       && ((ev_cnt_base + 13'h1) > {1'b0, maxev_q});

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ev_cnt_q  <= 13'h0;
            ev_over_q <= 1'b0;
        end
        else if (soft_rst)
        begin
            ev_cnt_q  <= 13'h0;
            ev_over_q <= 1'b0;
        end
        else
        begin
            if (i_ro_word && !(ev_over_q && !i_ro_event_start))
                ev_cnt_q <= ev_cnt_base + 13'h1;
            else
                ev_cnt_q <= ev_cnt_base;
            if (i_ro_event_start)
                ev_over_q <= over_hit;
            else if (over_hit)
                ev_over_q <= 1'b1;
        end
    end

    // ****************************************************************
    // partition full and read-out enables
    // ****************************************************************
    logic             full_hit;
    logic [NPART-1:0] ena_q;
    logic [NPART-1:0] hw_dis_q;
    logic [NPART-1:0] hw_clr;
    logic             ena_wr;

    // only the top pointer bits compare, so full trips well short of 8K words
    assign full_hit = i_ptr_valid
                    && (i_wr_ptr[`ROHP_PTR_HI:`ROHP_PTR_LO]
                        == 3'(i_rd_ptr[`ROHP_PTR_HI:`ROHP_PTR_LO] - `ROHP_FULL_GAP));
    assign ena_wr   = i_reg_wr && sel == rohp_pkg::SEL_PART_ENA;

    for (genvar n = 0; n < NPART; n++)
    begin : g_part
        assign hw_clr[n] = (full_hit && i_ptr_part == 5'(n))
                         || (over_hit && i_ro_part == 5'(n));

        // hardware clear beats a software set in the same cycle
        always_ff @(posedge i_mclk or negedge i_nrst)
        begin
            if (!i_nrst)
                ena_q[n] <= ENA_RST[n];
            else if (soft_rst)
                ena_q[n] <= ENA_RST[n];
            else if (hw_clr[n])
                ena_q[n] <= 1'b0;
            else if (ena_wr)
                ena_q[n] <= i_reg_wdata[n];
        end

        // sticky cause for the readout error line, cleared by re-enabling
        always_ff @(posedge i_mclk or negedge i_nrst)
        begin
            if (!i_nrst)
                hw_dis_q[n] <= 1'b0;
            else if (soft_rst)
                hw_dis_q[n] <= 1'b0;
            else if (hw_clr[n])
                hw_dis_q[n] <= 1'b1;
            else if (ena_wr && i_reg_wdata[n])
                hw_dis_q[n] <= 1'b0;
        end
    end

    assign o_part_enable = ena_q;

    // ****************************************************************
    // separator flags
    // ****************************************************************
    rohp_pkg::rohp_word_t sep_q;

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            sep_q <= 32'h0;
        else if (soft_rst)
            sep_q <= 32'h0;
        else if (i_sep_valid)
            sep_q <= i_sep_word;
    end

    // ****************************************************************
    // register read
    // ****************************************************************
    rohp_pkg::rohp_word_t rdata_q;

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            rdata_q <= 32'h0;
        else if (i_reg_rd)
        begin
            rdata_q <= 32'h0;
            case (sel)
                rohp_pkg::SEL_CTRL:
                begin
                    rdata_q[`ROHP_CTRL_BUFMODE]  <= ctrl_bufmode_q;
                    rdata_q[`ROHP_CTRL_LINKDOWN] <= ldn_s2_q;
                    rdata_q[`ROHP_CTRL_LINKRST]  <= ctrl_linkrst_q;
                    rdata_q[`ROHP_CTRL_FREEZE]   <= ctrl_freeze_q;
                end
                rohp_pkg::SEL_MAXEV:     rdata_q[11:0]      <= maxev_q;
                rohp_pkg::SEL_PART_ENA:  rdata_q[NPART-1:0] <= ena_q;
                rohp_pkg::SEL_SEP_FLAGS: rdata_q            <= sep_q;
                default:                 rdata_q            <= 32'h0;
            endcase
        end
    end

    assign o_reg_rdata = rdata_q;

    // ****************************************************************
    // output fifo
    // ****************************************************************
    logic [FIFO_AW:0] wptr_q;
    logic [FIFO_AW:0] rptr_q;
    logic             fifo_full;
    logic             fifo_empty;
    logic             fifo_we;
    logic             fifo_take;

    assign fifo_empty = (wptr_q == rptr_q);
    assign fifo_full  = (wptr_q[FIFO_AW] != rptr_q[FIFO_AW])
                      && (wptr_q[FIFO_AW-1:0] == rptr_q[FIFO_AW-1:0]);
    assign fifo_we    = i_ofifo_wvalid && !fifo_full;
    // empty read leaves the read register alone, so the last word repeats
    assign fifo_take  = i_fifo_read_space && (i_host_addr[`ROHP_CHAN_ABIT] == CHAN_SEL)
                      && !fifo_empty;

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wptr_q <= '0;
            rptr_q <= '0;
        end
        else if (soft_rst)
        begin
            wptr_q <= '0;
            rptr_q <= '0;
        end
        else
        begin
            if (fifo_we)
                wptr_q <= wptr_q + 1'b1;
            if (fifo_take)
                rptr_q <= rptr_q + 1'b1;
        end
    end

    rohp_fifo_mem #(
        .AW (FIFO_AW),
        .DW (32)
    ) u_mem (
        .i_mclk  (i_mclk),
        .i_we    (fifo_we),
        .i_waddr (wptr_q[FIFO_AW-1:0]),
        .i_wdata (i_ofifo_wdata),
        .i_re    (fifo_take),
        .i_raddr (rptr_q[FIFO_AW-1:0]),
        .o_rdata (o_fifo_rdata)
    );

    assign o_ofifo_wready = !fifo_full;
    assign o_dma_req      = !fifo_empty;

    // ****************************************************************
    // buffer memory second port
    // ****************************************************************
    logic [19:0] buf_addr_q;
    logic        buf_we_q;
    logic [31:0] buf_wdata_q;
    logic        buf_rd_q;
    logic [31:0] buf_rdata_q;
    logic        host_buf;

    assign host_buf = ctrl_bufmode_q && i_buffer_test_space;

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            buf_addr_q  <= 20'h0;
            buf_we_q    <= 1'b0;
            buf_wdata_q <= 32'h0;
            buf_rd_q    <= 1'b0;
        end
        else
        begin
            if (ctrl_bufmode_q)
                buf_addr_q <= {1'b0, i_host_addr[`ROHP_BUF_AHI:`ROHP_BUF_ALO]};
            else
                buf_addr_q <= i_int_buf_addr;
            buf_we_q    <= host_buf && i_host_wr;
            buf_wdata_q <= i_host_wdata;
            buf_rd_q    <= host_buf && !i_host_wr;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            buf_rdata_q <= 32'h0;
        else if (buf_rd_q)
            buf_rdata_q <= i_buf_rdata;
    end

    assign o_buf_addr       = buf_addr_q;
    assign o_buf_we         = buf_we_q;
    assign o_buf_wdata      = buf_wdata_q;
    assign o_buf_host_rdata = buf_rdata_q;
    assign o_buf_host_mode  = ctrl_bufmode_q;

    // ****************************************************************
    // host flags and shared interrupt lines
    // ****************************************************************
    logic elf_q;
    logic irq_ro_q;
    logic irq_link_q;
    logic irq_evid_q;

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            elf_q      <= 1'b1;
            irq_ro_q   <= 1'b0;
            irq_link_q <= 1'b0;
            irq_evid_q <= 1'b0;
        end
        else
        begin
            elf_q      <= i_elf_empty;
            irq_ro_q   <= i_irq_en[0] && (i_msg_fifo_full || (|hw_dis_q) || i_fe_parity_err);
            irq_link_q <= i_irq_en[1] && (i_link_parity_err || !ldn_s2_q);
            irq_evid_q <= i_irq_en[2] && i_event_id_out;
        end
    end

    // pins only ever pull low, so the other channel can share them
    assign o_elf_empty_flag         = elf_q;
    assign o_readout_error_irq      = 1'b0;
    assign o_readout_error_irq_oe   = irq_ro_q;
    assign o_link_error_irq         = 1'b0;
    assign o_link_error_irq_oe      = irq_link_q;
    assign o_event_id_window_irq    = 1'b0;
    assign o_event_id_window_irq_oe = irq_evid_q;

endmodule // rohp_channel

// ### verilog/rohp_regs.svh
`ifndef ROHP_REGS_SVH
`define ROHP_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define ROHP_OFS_CTRL        6'h1b
`define ROHP_OFS_MAXEV       6'h1e
`define ROHP_OFS_PART_ENA    6'h21
`define ROHP_OFS_SEP_FLAGS   6'h22

// ****************************************************************
// control register fields
// ****************************************************************
`define ROHP_CTRL_BUFMODE    2
`define ROHP_CTRL_LINKDOWN   8
`define ROHP_CTRL_LINKRST    10
`define ROHP_CTRL_FREEZE     11

// ****************************************************************
// reset values and fixed figures
// ****************************************************************
`define ROHP_MAXEV_RST       12'h400
`define ROHP_FREEZE_RST      1'b1
`define ROHP_FULL_GAP        3'h2
`define ROHP_PTR_HI          12
`define ROHP_PTR_LO          10
`define ROHP_CHAN_ABIT       20
`define ROHP_BUF_AHI         19
`define ROHP_BUF_ALO         1

`endif

// ### verilog/rohp_pkg.sv
package rohp_pkg;

    // register selected by the register port address
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_CTRL,
        SEL_MAXEV,
        SEL_PART_ENA,
        SEL_SEP_FLAGS
    } rohp_regsel_e;

    typedef logic [31:0] rohp_word_t;

endpackage

// ### verilog/rohp_fifo_mem.sv
`timescale 1ns/1ns

module rohp_fifo_mem #(
    parameter int AW = 9,
    parameter int DW = 32
) (
    input  wire logic          i_mclk,   // clock
    input  wire logic          i_we,     // write enable
    input  wire logic [AW-1:0] i_waddr,  // write address
    input  wire logic [DW-1:0] i_wdata,  // write data
    input  wire logic          i_re,     // read enable
    input  wire logic [AW-1:0] i_raddr,  // read address
    output logic      [DW-1:0] o_rdata   // registered read data
);

    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] rdata_q;

    // no reset on the array; read register keeps last word when idle
    always_ff @(posedge i_mclk)
    begin
        if (i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_re)
        begin
            rdata_q <= mem[i_raddr];
        end
    end

    assign o_rdata = rdata_q;

endmodule // rohp_fifo_mem

// ### bench/rohp_host_model.sv
`timescale 1ns/1ns

module rohp_host_model (
    input  wire logic [2:0] i_oe_a,    // channel a line drives
    input  wire logic [2:0] i_oe_b,    // channel b line drives
    output logic      [2:0] o_irq_line // shared lines, low asserted
);
    // pulled up at the host; either channel pulls a line low
    assign o_irq_line = ~(i_oe_a | i_oe_b);
endmodule // rohp_host_model

// ### bench/rohp_channel_checker.sv
`timescale 1ns/1ns

module rohp_channel_checker (
    input wire logic        i_mclk, i_nrst, i_reg_rd, i_ptr_valid, i_sep_valid, i_ofifo_wvalid, i_event_id_out,
    input wire logic        i_elf_empty, o_dma_req, o_ofifo_wready, o_link_reset, o_freeze, o_elf_empty_flag,
    input wire logic        i_reg_wr, o_event_id_window_irq_oe,
    input wire logic [2:0]  i_irq_en,
    input wire logic [4:0]  i_ptr_part,
    input wire logic [5:0]  i_reg_addr,
    input wire logic [12:0] i_wr_ptr, i_rd_ptr,
    input wire logic [17:0] o_part_enable,
    input wire logic [31:0] i_reg_wdata, i_sep_word, o_reg_rdata
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    property p_full;
        i_ptr_valid && i_ptr_part < 5'h12 && i_wr_ptr[12:10] == i_rd_ptr[12:10] - 3'h2
            |=> !o_part_enable[$past(i_ptr_part)];
    endproperty
    a_full: assert property (p_full) else $error("full partition kept its enable");
    property p_sep;
        i_reg_rd && i_reg_addr == 6'h22 && $past(i_sep_valid, 2) && !$past(i_sep_valid)
            |=> o_reg_rdata == $past(i_sep_word, 3);
    endproperty
    a_sep: assert property (p_sep) else $error("separator word not captured");
    property p_ena;
        i_reg_rd && i_reg_addr == 6'h21 |=> o_reg_rdata == {14'h0, $past(o_part_enable)};
    endproperty
    a_ena: assert property (p_ena) else $error("enable readback wrong");
    property p_dma;
        $rose(o_dma_req) |-> $past(i_ofifo_wvalid && o_ofifo_wready);
    endproperty
    a_dma: assert property (p_dma) else $error("dma request without a stored word");
    property p_lrst;
        o_link_reset |-> $past(i_reg_wr && i_reg_addr == 6'h1b && i_reg_wdata[10], 2) ##1 !o_link_reset;
    endproperty
    a_lrst: assert property (p_lrst) else $error("link reset pulse wrong");
    property p_frz;
        $rose(i_nrst) |-> o_freeze;
    endproperty
    a_frz: assert property (p_frz) else $error("not frozen after reset");
    property p_evid;
        $past(i_nrst) |-> o_event_id_window_irq_oe == $past(i_irq_en[2] && i_event_id_out);
    endproperty
    a_evid: assert property (p_evid) else $error("event id line wrong");
    property p_elf;
        $past(i_nrst) |-> o_elf_empty_flag == $past(i_elf_empty);
    endproperty
    a_elf: assert property (p_elf) else $error("length fifo empty flag wrong");
endmodule // rohp_channel_checker

bind rohp_channel rohp_channel_checker i_chk (.*);

// ### bench/testbench.sv
`timescale 1ns/1ns

module testbench;
    logic i_mclk = 0, i_nrst = 0, i_logic_rst_n = 1, i_reg_wr = 0, i_reg_rd = 0, i_fifo_read_space = 0;
    logic i_buffer_test_space = 0, i_host_wr = 0, i_ofifo_wvalid = 0, i_ptr_valid = 0, i_ro_event_start = 0;
    logic i_ro_word = 0, i_sep_valid = 0, i_link_down_n = 1, i_msg_fifo_full = 0, i_fe_parity_err = 0;
    logic i_link_parity_err = 0, i_event_id_out = 0, i_elf_empty = 1;
    logic [2:0] i_irq_en = 3'h7;
    logic [5:0] i_reg_addr = 6'h0;
    logic [31:0] i_reg_wdata = 32'h0, i_host_wdata = 32'h0, i_ofifo_wdata = 32'h0, i_buf_rdata = 32'h0, i_sep_word = 32'h0;
    logic [20:0] i_host_addr = 21'h0;
    logic [19:0] i_int_buf_addr = 20'h0, o_buf_addr;
    logic [4:0] i_ptr_part = 5'h0, i_ro_part = 5'h0;
    logic [12:0] i_wr_ptr = 13'h0, i_rd_ptr = 13'h0;
    logic [31:0] o_reg_rdata, o_fifo_rdata, o_buf_host_rdata, o_buf_wdata;
    logic [17:0] o_part_enable;
    logic o_dma_req, o_ofifo_wready, o_buf_we, o_buf_host_mode, o_link_reset, o_freeze, o_elf_empty_flag;
    logic o_readout_error_irq, o_readout_error_irq_oe, o_link_error_irq, o_link_error_irq_oe;
    logic o_event_id_window_irq, o_event_id_window_irq_oe;
    wire [2:0] irq_line;
    wire i_readout_error_irq = irq_line[0], i_link_error_irq = irq_line[1], i_event_id_window_irq = irq_line[2];
    int fail_count = 0, checks = 0;
    always #4 i_mclk = ~i_mclk;
    rohp_channel i_dut (.*);
    rohp_host_model i_host (.i_oe_a({o_event_id_window_irq_oe, o_link_error_irq_oe, o_readout_error_irq_oe}),
                            .i_oe_b(3'h0), .o_irq_line(irq_line));
    // ****************************************************************
    // access tasks
    // ****************************************************************
    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask
    task wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge i_mclk) {i_reg_wr, i_reg_addr, i_reg_wdata} <= {1'b1, a, d};
        @(posedge i_mclk) i_reg_wr <= 1'b0;
    endtask
    task rc(input logic [5:0] a, input logic [31:0] e);
        @(posedge i_mclk) {i_reg_rd, i_reg_addr} <= {1'b1, a};
        @(posedge i_mclk) i_reg_rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), o_reg_rdata, e);
    endtask
    task pf(input logic [31:0] d);
        @(posedge i_mclk) {i_ofifo_wvalid, i_ofifo_wdata} <= {1'b1, d};
        @(posedge i_mclk) i_ofifo_wvalid <= 1'b0;
    endtask
    task fr(input logic a20, input logic [31:0] e);
        @(posedge i_mclk) {i_fifo_read_space, i_host_addr} <= {1'b1, a20, 20'h0};
        @(posedge i_mclk) i_fifo_read_space <= 1'b0;
        @(posedge i_mclk) #1 chk("fifo word", o_fifo_rdata, e);
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        repeat (4) @(posedge i_mclk);
        i_nrst <= 1'b1;
        rc(6'h1e, 32'h400);
        rc(6'h1b, 32'h900);
        rc(6'h3f, 32'h0);
        rc(6'h21, 32'h0);
        wr(6'h21, 32'h3ffff);
        wr(6'h22, 32'hffffffff);
        rc(6'h21, 32'h3ffff);
        rc(6'h22, 32'h0);
        @(posedge i_mclk) {i_sep_valid, i_sep_word} <= {1'b1, 32'ha5c30f17};
        @(posedge i_mclk) i_sep_valid <= 1'b0;
        rc(6'h22, 32'ha5c30f17);
        $display("test registers done");
        @(posedge i_mclk) {i_ptr_valid, i_ptr_part, i_wr_ptr, i_rd_ptr} <= {1'b1, 5'h6, 13'h1800, 13'h0423};
        @(posedge i_mclk) {i_ptr_part, i_wr_ptr} <= {5'h5, 13'h1c00};
        @(posedge i_mclk) i_ptr_valid <= 1'b0;
        rc(6'h21, 32'h3ffdf);
        chk("readout irq line", {31'h0, irq_line[0]}, 32'h0);
        wr(6'h1e, 32'h2);
        @(posedge i_mclk) {i_ro_event_start, i_ro_word, i_ro_part} <= {2'h3, 5'h7};
        @(posedge i_mclk) i_ro_event_start <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_ro_word <= 1'b0;
        rc(6'h21, 32'h3ff5f);
        $display("test partition disable done");
        pf(32'h11);
        pf(32'h22);
        pf(32'h33);
        @(negedge i_mclk) chk("dma request", {31'h0, o_dma_req}, 32'h1);
        fr(1'b0, 32'h11);
        fr(1'b0, 32'h22);
        fr(1'b0, 32'h33);
        chk("dma request", {31'h0, o_dma_req}, 32'h0);
        fr(1'b0, 32'h33);
        pf(32'h44);
        fr(1'b1, 32'h33);
        fr(1'b0, 32'h44);
        $display("test output fifo done");
        @(posedge i_mclk) i_logic_rst_n <= 1'b0;
        repeat (3) @(posedge i_mclk);
        i_logic_rst_n <= 1'b1;
        rc(6'h21, 32'h0);
        wr(6'h1b, 32'hc00);
        wr(6'h1b, 32'h400);
        rc(6'h1b, 32'h500);
        chk("freeze", {31'h0, o_freeze}, 32'h0);
        @(posedge i_mclk) {i_event_id_out, i_elf_empty} <= 2'h2;
        @(posedge i_mclk) {i_event_id_out, i_elf_empty, i_link_down_n} <= 3'h2;
        @(negedge i_mclk) chk("irq line, flag", {30'h0, irq_line[2], o_elf_empty_flag}, 32'h0);
        repeat (4) @(posedge i_mclk);
        #1 chk("link irq line", {31'h0, irq_line[1]}, 32'h0);
        wr(6'h1b, 32'h4);
        @(posedge i_mclk) {i_buffer_test_space, i_host_wr, i_host_addr} <= {2'h3, 21'hfffff};
        @(posedge i_mclk) #1 chk("buf", {11'h0, o_buf_we, o_buf_addr}, 32'h17ffff);
        $display("test interrupts done");
        stop_test;
    end
    // whole sequence needs about 90 cycles
    initial
    begin
        repeat (2000) @(posedge i_mclk);
        fail_count++;
        stop_test;
    end
endmodule // testbench
